// [wlpg_pkg.sv]
package wlpg_pkg;
  localparam logic [11:0] OFF_LEVEL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_CLEAR = 12'h008;
  localparam logic [11:0] OFF_ENABLE = 12'h00C;
  localparam logic [11:0] OFF_COND = 12'h010;
  localparam int BIT_EXT_A_POL = 0;
  localparam int BIT_EXT_B_POL = 1;
  localparam int BIT_GP_POL = 2;
  localparam int BIT_PIN_GATE = 4;
  localparam logic [7:0] LEVEL_WMASK = 8'h17;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam logic [2:0] EV_RESET = 3'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef struct packed {
    logic ext_a;
    logic ext_b;
    logic gp;
  } wlpg_lines_type;
endpackage : wlpg_pkg

// [wlpg_sync.sv]
`timescale 1ns/1ps
module wlpg_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : wlpg_sync

// [wlpg_top.sv]
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - Gate on: line b low tristates host pins
// - General polarity one: high means wake-up
// - General polarity zero: low means wake-up
// - Line b polarity one: low means wake-up
// - Line b polarity zero: high means wake-up
// - Line a polarity: one high, zero low
module wlpg_top (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire wlpg_pkg::wlpg_lines_type irq_lines,
  output wlpg_pkg::wlpg_lines_type wake_cond,
  output logic host_pins_oe,
  output logic irq
);
  import wlpg_pkg::*;

  wlpg_lines_type lines_sync;
  logic [7:0] interrupt_level_control;
  logic [7:0] next_interrupt_level_control;
  logic [2:0] status;
  logic [2:0] next_status;
  logic [2:0] enable;
  logic [2:0] next_enable;
  logic wr_pend;
  logic next_wr_pend;
  logic [11:0] wr_addr;
  logic [11:0] next_wr_addr;
  logic [31:0] next_hrdata;
  wlpg_lines_type next_wake;
  logic next_oe;
  logic next_irq;
  logic [2:0] prev_cond;
  logic [2:0] rise;
  logic access;

  wlpg_sync #(.WIDTH(3)) u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .din(irq_lines),
    .dout(lines_sync)
  );

  assign access = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_comb begin
    next_wake.ext_a = interrupt_level_control[BIT_EXT_A_POL] ? lines_sync.ext_a : !lines_sync.ext_a;
    next_wake.ext_b = interrupt_level_control[BIT_EXT_B_POL] ? !lines_sync.ext_b : lines_sync.ext_b;
    next_wake.gp = interrupt_level_control[BIT_GP_POL] ? lines_sync.gp : !lines_sync.gp;
    next_oe = !interrupt_level_control[BIT_PIN_GATE] || lines_sync.ext_b;
  end

  // Wake events are rising edges of the condition; set beats clear
  assign rise = {wake_cond.ext_a, wake_cond.ext_b, wake_cond.gp} & ~prev_cond;

  always_comb begin
    next_wr_pend = access && hwrite;
    next_wr_addr = access ? haddr[11:0] : wr_addr;
    next_interrupt_level_control = interrupt_level_control;
    next_enable = enable;
    next_status = status;
    if (wr_pend && wr_addr == OFF_CLEAR) begin
      next_status = status & ~hwdata[2:0];
    end
    next_status = next_status | rise;
    if (wr_pend && wr_addr == OFF_LEVEL) begin
      next_interrupt_level_control = hwdata[7:0] & LEVEL_WMASK;
    end
    if (wr_pend && wr_addr == OFF_ENABLE) begin
      next_enable = hwdata[2:0];
    end
    next_irq = |(next_status & next_enable);
    next_hrdata = 32'h0000_0000;
    if (access && !hwrite) begin
      unique case (haddr[11:0])
        OFF_LEVEL: next_hrdata = {24'h00_0000, interrupt_level_control};
        OFF_STATUS: next_hrdata = {29'h0000_0000, status};
        OFF_ENABLE: next_hrdata = {29'h0000_0000, enable};
        OFF_COND: next_hrdata = {29'h0000_0000, wake_cond.ext_a, wake_cond.ext_b, wake_cond.gp};
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_level_control <= LEVEL_RESET;
      status <= EV_RESET;
      enable <= EV_RESET;
      wr_pend <= 1'b0;
      wr_addr <= OFF_LEVEL;
      hrdata <= 32'h0000_0000;
      wake_cond <= '0;
      prev_cond <= EV_RESET;
      host_pins_oe <= 1'b1;
      irq <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      interrupt_level_control <= next_interrupt_level_control;
      status <= next_status;
      enable <= next_enable;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      wake_cond <= next_wake;
      prev_cond <= {wake_cond.ext_a, wake_cond.ext_b, wake_cond.gp};
      host_pins_oe <= next_oe;
      irq <= next_irq;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  a_pin_gate: assert property (@(posedge clock) disable iff (!arst_n)
    arst_n |=> host_pins_oe == (!$past(interrupt_level_control[BIT_PIN_GATE]) || $past(lines_sync.ext_b)))
    else $error("host pin enable wrong");
  a_gp_high: assert property (@(posedge clock) disable iff (!arst_n)
    arst_n && interrupt_level_control[BIT_GP_POL] && lines_sync.gp |=> wake_cond.gp)
    else $error("gp high not wake");
  a_gp_low: assert property (@(posedge clock) disable iff (!arst_n)
    arst_n && !interrupt_level_control[BIT_GP_POL] && !lines_sync.gp |=> wake_cond.gp)
    else $error("gp low not wake");
  a_b_inverted: assert property (@(posedge clock) disable iff (!arst_n)
    arst_n && interrupt_level_control[BIT_EXT_B_POL] && !lines_sync.ext_b |=> wake_cond.ext_b)
    else $error("line b low not wake");
  a_b_direct: assert property (@(posedge clock) disable iff (!arst_n)
    arst_n && !interrupt_level_control[BIT_EXT_B_POL] |=> wake_cond.ext_b == $past(lines_sync.ext_b))
    else $error("line b high sense wrong");
  a_a_sense: assert property (@(posedge clock) disable iff (!arst_n)
    arst_n |=> wake_cond.ext_a == ($past(lines_sync.ext_a) ~^ $past(interrupt_level_control[BIT_EXT_A_POL])))
    else $error("line a sense wrong");
  a_level_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_pend && wr_addr == OFF_LEVEL |=> interrupt_level_control == ($past(hwdata[7:0]) & LEVEL_WMASK))
    else $error("level write lost");
  a_sync_delay: assert property (@(posedge clock) disable iff (!arst_n)
    // Synchroniser stages hold reset values for two edges after release
    $past(arst_n, 2) |-> lines_sync == $past(irq_lines, 2))
    else $error("sync path wrong");
  a_irq_level: assert property (@(posedge clock) disable iff (!arst_n)
    1'b1 |-> irq == |(status & enable))
    else $error("irq wrong");
endmodule : wlpg_top

// [wlpg_line_model.sv]
`timescale 1ns/1ps
module wlpg_line_model (
  input wire logic clock,
  input wire logic [2:0] want,
  output wlpg_pkg::wlpg_lines_type lines
);
  // Pin levels, no idle pattern: sources hold a level between changes
  always_ff @(posedge clock) begin
    lines <= want;
  end
endmodule : wlpg_line_model

// [tb.sv]
`timescale 1ns/1ps
module tb;
  import wlpg_pkg::*;
  logic clock = 0, arst_n = 0, hsel = 0, hwrite = 0, hreadyout, hresp, host_pins_oe, irq;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, want = 3'h7;
  logic [7:0] lvl;
  wlpg_lines_type lines, wake_cond;
  int seed = 12879, bad_count = 0, comparisons = 0;
  initial forever #50 clock = ~clock;
  wlpg_line_model u_src (.clock(clock), .want(want), .lines(lines));
  wlpg_top u_dut (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .irq_lines(lines), .wake_cond(wake_cond), .host_pins_oe(host_pins_oe), .irq(irq));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task wait_ready;
    int n;
    n = 0;
    // Ready and read data are taken at the rising edge, before the slave's registers move
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 50);
    r = hrdata;
    if (n >= 50) begin bad_count++; tally_and_finish; end
  endtask : wait_ready
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= HTRANS_NONSEQ; hwrite <= w; haddr <= {20'h00000, a};
    wait_ready;
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_ready;
    chk({31'h0, hresp}, 32'h0);
  endtask : ahb
  function automatic logic [2:0] wake(input logic [7:0] l, input logic [2:0] p);
    // Line b polarity has the inverted sense
    wake = {p[2] == l[BIT_EXT_A_POL], p[1] != l[BIT_EXT_B_POL], p[0] == l[BIT_GP_POL]};
  endfunction : wake
  task apply(input logic [7:0] l, input logic [2:0] p);
    ahb(1'b1, OFF_LEVEL, {24'h000000, l});
    want <= p;
    repeat (5) @(posedge clock);
    ahb(1'b0, OFF_COND, 32'h0);
    chk(r, {29'h0, wake(l, p)});
    chk({29'h0, wake_cond}, {29'h0, wake(l, p)});
    chk({31'h0, host_pins_oe}, {31'h0, !l[BIT_PIN_GATE] || p[1]});
  endtask : apply
  initial begin
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    chk({31'h0, host_pins_oe}, 32'h1);
    ahb(1'b1, OFF_LEVEL, 32'hFFFFFFFF);
    ahb(1'b0, OFF_LEVEL, 32'h0);
    chk(r, {24'h0, LEVEL_WMASK});
    ahb(1'b0, 12'h020, 32'h0);
    chk(r, 32'h0);
    $display("test registers done");
    apply(8'h10, 3'h5);
    apply(8'h10, 3'h7);
    for (int i = 0; i < 30; i++) begin
      lvl = $random(seed);
      apply(lvl & LEVEL_WMASK, 3'($random(seed)));
    end
    $display("test levels done");
    apply(8'h02, 3'h7);
    ahb(1'b1, OFF_CLEAR, 32'h7);
    ahb(1'b1, OFF_ENABLE, 32'h7);
    apply(8'h02, 3'h0);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk(r, 32'h7);
    chk({31'h0, irq}, 32'h1);
    ahb(1'b1, OFF_ENABLE, 32'h0);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk(r, 32'h7);
    chk({31'h0, irq}, 32'h0);
    ahb(1'b1, OFF_ENABLE, 32'h7);
    ahb(1'b1, OFF_CLEAR, 32'h7);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    tally_and_finish;
  end
endmodule : tb
